// >>> design/gtl_pkg.sv
package gtl_pkg;

    // addressing groups on the low seven data bits
    localparam logic [6:0] GTL_LAG_BASE = 7'h20;
    localparam logic [6:0] GTL_TAG_BASE = 7'h40;
    localparam logic [6:0] GTL_UNL_CMD  = 7'h3F;
    localparam logic [6:0] GTL_UNT_CMD  = 7'h5F;
    localparam logic [1:0] GTL_TAG_GRP  = 2'h2;

    // reset values
    localparam logic [7:0] GTL_BYTE_RST = 8'h00;
    localparam logic [15:0] GTL_SYNC_RST = 16'hFFFF;

    // data settle before the source looks at the acceptors
    localparam int GTL_CLK_NS     = 25;
    localparam int GTL_SETTLE_NS  = 100;
    localparam int GTL_SETTLE_CYC = (GTL_SETTLE_NS + GTL_CLK_NS - 1) / GTL_CLK_NS;
    localparam logic [2:0] GTL_SETTLE_LD = 3'(GTL_SETTLE_CYC - 1);

    // one bit per bus line, raw level, enable or true-flag depending on use
    typedef struct packed {
        logic [7:0] dio;
        logic       atn;
        logic       ifc;
        logic       ren;
        logic       eoi;
        logic       srq;
        logic       dav;
        logic       nrfd;
        logic       ndac;
    } gtl_bus_t;

    typedef enum logic [1:0] {ACC_IDLE, ACC_RDY, ACC_ACPT} gtl_acc_st_t;
    typedef enum logic [1:0] {SRC_IDLE, SRC_SETL, SRC_WAIT, SRC_VAL} gtl_src_st_t;

endpackage

// >>> design/gtl_device.sv
`timescale 1ns/100ps
`default_nettype none

module gtl_device
    import gtl_pkg::*;
(
    // clock and reset
    input  wire logic     clk,
    input  wire logic     sys_rst,
    // bus pins: raw level, driven level, drive enable
    input  wire gtl_bus_t bus_i,
    output var  gtl_bus_t bus_o,
    output var  gtl_bus_t bus_oe,
    // static setting
    input  wire logic [4:0] pri_addr,
    // talk stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // listen stream and commands
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    output logic            cmd_valid,
    output logic [7:0]      cmd_data,
    // service and status
    input  wire logic       srq_req,
    output logic            talk_act,
    output logic            listen_act,
    output logic            remote
);

    logic [15:0] meta_r;
    logic [15:0] sync_r;
    gtl_bus_t    ln;

    // first stage feeds only the second
    // one flop pair for each of the sixteen lines
    for (genvar i = 0; i < 16; i++) begin : g_sync
        always_ff @(posedge clk) begin
            meta_r[i] <= sys_rst ? GTL_SYNC_RST[i] : bus_i[i];
            sync_r[i] <= sys_rst ? GTL_SYNC_RST[i] : meta_r[i];
        end
    end

    assign ln = gtl_bus_t'(~sync_r);

    gtl_acc_st_t acc_r, acc_nxt;
    gtl_src_st_t src_r, src_nxt;
    logic        talk_r, talk_nxt, listen_r, listen_nxt, remote_r, remote_nxt;
    logic        srq_r, srq_nxt, eoi_r, eoi_nxt;
    logic [7:0]  dout_r, dout_nxt;
    logic [2:0]  cnt_r, cnt_nxt;
    logic        rxv_r, rxv_nxt, rxe_r, rxe_nxt, cmv_r, cmv_nxt;
    logic [7:0]  rxd_r, rxd_nxt, cmd_r, cmd_nxt;
    logic        acc_en, src_en, can_take, take;
    logic [6:0]  lag, tag, cb;

    assign lag      = GTL_LAG_BASE | {2'b00, pri_addr};
    assign tag      = GTL_TAG_BASE | {2'b00, pri_addr};
    assign cb       = ln.dio[6:0];
    // a talker that is also a listener hears its own bytes
    assign acc_en   = ln.atn | listen_r;
    assign src_en   = talk_r & ~ln.atn;
    // commands are never held off; data waits for the user
    assign can_take = ln.atn | rx_ready;
    assign take     = (acc_r == ACC_RDY) & ln.dav & can_take;

    always_comb begin
        acc_nxt    = acc_r;
        src_nxt    = src_r;
        talk_nxt   = talk_r;
        listen_nxt = listen_r;
        remote_nxt = ln.ren;
        srq_nxt    = srq_req;
        eoi_nxt    = eoi_r;
        dout_nxt   = dout_r;
        cnt_nxt    = cnt_r;
        rxv_nxt    = 1'b0;
        rxe_nxt    = rxe_r;
        rxd_nxt    = rxd_r;
        cmv_nxt    = 1'b0;
        cmd_nxt    = cmd_r;
        tx_ready   = 1'b0;

        case (acc_r)
            ACC_IDLE: begin
                if (acc_en) acc_nxt = ACC_RDY;
            end
            ACC_RDY: begin
                if (!acc_en) begin
                    acc_nxt = ACC_IDLE;
                end else if (take) begin
                    acc_nxt = ACC_ACPT;
                    if (ln.atn) begin
                        cmv_nxt = 1'b1;
                        cmd_nxt = ln.dio;
                        // secondary bytes match no case below
                        if (cb == lag) listen_nxt = 1'b1;
                        else if (cb == GTL_UNL_CMD) listen_nxt = 1'b0;
                        if (cb == tag) talk_nxt = 1'b1;
                        else if (cb == GTL_UNT_CMD) talk_nxt = 1'b0;
                        else if (cb[6:5] == GTL_TAG_GRP) talk_nxt = 1'b0;
                    end else begin
                        rxv_nxt = 1'b1;
                        rxd_nxt = ln.dio;
                        rxe_nxt = ln.eoi;
                    end
                end
            end
            ACC_ACPT: begin
                if (!acc_en) acc_nxt = ACC_IDLE;
                else if (!ln.dav) acc_nxt = ACC_RDY;
            end
            default: acc_nxt = ACC_IDLE;
        endcase

        case (src_r)
            SRC_IDLE: begin
                if (src_en && tx_valid) begin
                    dout_nxt = tx_data;
                    eoi_nxt  = tx_last;
                    cnt_nxt  = GTL_SETTLE_LD;
                    src_nxt  = SRC_SETL;
                end
            end
            SRC_SETL: begin
                cnt_nxt = cnt_r - 3'd1;
                if (cnt_r == 3'd0) src_nxt = SRC_WAIT;
            end
            SRC_WAIT: begin
                if (!ln.nrfd && ln.ndac) src_nxt = SRC_VAL;
            end
            SRC_VAL: begin
                if (!ln.ndac) begin
                    src_nxt  = SRC_IDLE;
                    tx_ready = src_en;
                end
            end
            default: src_nxt = SRC_IDLE;
        endcase
        // byte is only consumed on a completed handshake; ATN aborts and retries
        if (!src_en) src_nxt = SRC_IDLE;

        if (ln.ifc) begin
            talk_nxt   = 1'b0;
            listen_nxt = 1'b0;
            acc_nxt    = ACC_IDLE;
            src_nxt    = SRC_IDLE;
            rxv_nxt    = 1'b0;
            cmv_nxt    = 1'b0;
            tx_ready   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_r    <= ACC_IDLE;
            src_r    <= SRC_IDLE;
            talk_r   <= 1'b0;
            listen_r <= 1'b0;
            remote_r <= 1'b0;
            srq_r    <= 1'b0;
            eoi_r    <= 1'b0;
            dout_r   <= GTL_BYTE_RST;
            cnt_r    <= 3'd0;
            rxv_r    <= 1'b0;
            rxe_r    <= 1'b0;
            rxd_r    <= GTL_BYTE_RST;
            cmv_r    <= 1'b0;
            cmd_r    <= GTL_BYTE_RST;
        end else begin
            acc_r    <= acc_nxt;
            src_r    <= src_nxt;
            talk_r   <= talk_nxt;
            listen_r <= listen_nxt;
            remote_r <= remote_nxt;
            srq_r    <= srq_nxt;
            eoi_r    <= eoi_nxt;
            dout_r   <= dout_nxt;
            cnt_r    <= cnt_nxt;
            rxv_r    <= rxv_nxt;
            rxe_r    <= rxe_nxt;
            rxd_r    <= rxd_nxt;
            cmv_r    <= cmv_nxt;
            cmd_r    <= cmd_nxt;
        end
    end

    logic src_drv;
    assign src_drv = (src_r != SRC_IDLE);

    // open drain: level always low, only the enables move
    assign bus_o = '0;
    always_comb begin
        bus_oe      = '0;
        bus_oe.dio  = src_drv ? dout_r : 8'h00;
        bus_oe.eoi  = src_drv & eoi_r;
        bus_oe.dav  = (src_r == SRC_VAL);
        bus_oe.srq  = srq_r;
        bus_oe.nrfd = (acc_r == ACC_ACPT) | ((acc_r == ACC_RDY) & ~can_take);
        bus_oe.ndac = (acc_r == ACC_RDY);
    end

    assign rx_valid   = rxv_r;
    assign rx_data    = rxd_r;
    assign rx_end     = rxe_r;
    assign cmd_valid  = cmv_r;
    assign cmd_data   = cmd_r;
    assign talk_act   = talk_r;
    assign listen_act = listen_r;
    assign remote     = remote_r;

    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (sys_rst);

    dav_owner_a: assert property (bus_oe.dav |-> $past(talk_r && !ln.atn))
        else $error("DAV driven while not active talker");
    dav_gate_a: assert property ($rose(bus_oe.dav) |-> $past(!ln.nrfd && ln.ndac))
        else $error("DAV asserted before ready and not accepted");
    // an ATN abort mid-settle never reaches the wait state
    settle_a: assert property (src_r == SRC_WAIT && $past(src_r == SRC_SETL)
        |-> $past(src_r == SRC_SETL, 4))
        else $error("data settle shorter than four cycles");
    ifc_clear_a: assert property (ln.ifc |=> !talk_r && !listen_r)
        else $error("IFC did not clear addressing");
    listen_addr_a: assert property (take && ln.atn && cb == lag && !ln.ifc |=> listen_r)
        else $error("listen address not recognised");
    talk_addr_a: assert property (take && ln.atn && cb == tag && !ln.ifc |=> talk_r)
        else $error("talk address not recognised");
    secondary_hold_a: assert property (take && ln.atn && cb[6:5] == 2'b11 && !ln.ifc
        |=> $stable(talk_r) && $stable(listen_r))
        else $error("secondary address changed addressing");
    hold_off_a: assert property (acc_r == ACC_RDY && !ln.atn && !rx_ready |-> bus_oe.nrfd)
        else $error("NRFD released while not ready");
    accept_a: assert property (take && acc_en && !ln.ifc
        |=> bus_oe.nrfd && !bus_oe.ndac ##0 (rx_valid || cmd_valid))
        else $error("accepted byte without NRFD low and NDAC release");
    data_kind_a: assert property (rx_valid |-> $past(!ln.atn))
        else $error("data byte reported while ATN true");
    data_hold_a: assert property (src_r == SRC_VAL && $past(src_r == SRC_VAL)
        |-> $stable(bus_oe.dio) && $stable(bus_oe.eoi))
        else $error("data changed during valid phase");
    remote_a: assert property (ln.ren |=> remote)
        else $error("REN did not set remote");

    // addressing, release, IFC, command-kind and end-mark checks
    unlisten_a: assert property (take && ln.atn && cb == GTL_UNL_CMD && cb != lag
        |=> !listen_r)
        else $error("unlisten did not clear listener");
    untalk_other_a: assert property (take && ln.atn && cb[6:5] == GTL_TAG_GRP && cb != tag
        |=> !talk_r)
        else $error("another talk address left this talker active");
    src_release_a: assert property (tx_ready |=> !bus_oe.dav)
        else $error("DAV still driven after acceptance");
    ready_again_a: assert property (acc_r == ACC_ACPT && acc_en && !ln.dav && !ln.ifc
        |=> acc_r == ACC_RDY)
        else $error("acceptor not ready again after DAV release");
    ifc_quiet_a: assert property (ln.ifc |=> !rx_valid && !cmd_valid && !bus_oe.dav)
        else $error("IFC did not quiet the interface");
    cmd_kind_a: assert property (cmd_valid |-> $past(ln.atn))
        else $error("command byte reported while ATN false");
    idle_release_a: assert property (acc_r == ACC_IDLE |-> !bus_oe.nrfd && !bus_oe.ndac)
        else $error("idle acceptor pulls a handshake line");
    end_mark_a: assert property (rx_valid |-> rx_end == $past(ln.eoi))
        else $error("end mark does not follow EOI");

    listen_c: cover property (!listen_r ##1 listen_r);
    talk_byte_c: cover property (tx_ready && tx_last);
    rx_end_c: cover property (rx_valid && rx_end);
    ifc_c: cover property (talk_r ##1 ln.ifc);
    untalk_c: cover property (talk_r && !ln.ifc ##1 !talk_r);

endmodule

`default_nettype wire

// >>> verif/gtl_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none

module gtl_ctl_model
    import gtl_pkg::*;
(
    // clock
    input  wire logic     clk,
    // resolved line levels, released lines read high
    input  wire gtl_bus_t lvl,
    // lines this controller pulls low
    output var  gtl_bus_t pull
);
    initial pull = '0;

    // sample away from the edge so registered outputs have landed
    task automatic hold(input gtl_bus_t m, input gtl_bus_t v, output bit ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            @(negedge clk);
            ok = ((lvl & m) === v);
        end
        @(posedge clk);
    endtask

    task automatic drive(input gtl_bus_t m, input gtl_bus_t v);
        @(posedge clk);
        pull <= gtl_bus_t'((pull & ~m) | v);
    endtask

    task automatic send(input bit atn, input logic [7:0] b, input bit eoi, output bit ok);
        @(posedge clk);
        pull.atn  <= atn;
        pull.nrfd <= 1'b0;
        pull.ndac <= 1'b0;
        pull.dio  <= b;
        pull.eoi  <= eoi;
        repeat (4) @(posedge clk);
        hold(16'h0003, 16'h0002, ok);
        if (ok) begin
            pull.dav <= 1'b1;
            hold(16'h0001, 16'h0001, ok);
        end
        pull.dav <= 1'b0;
        pull.dio <= 8'h00;
        pull.eoi <= 1'b0;
    endtask

    // not ready again on exit so the source is held off between bytes
    task automatic recv(output logic [7:0] b, output bit eoi, output bit ok);
        @(posedge clk);
        pull.nrfd <= 1'b0;
        pull.ndac <= 1'b1;
        hold(16'h0004, 16'h0000, ok);
        b = ~lvl.dio;
        eoi = ~lvl.eoi;
        pull.nrfd <= 1'b1;
        pull.ndac <= 1'b0;
        hold(16'h0004, 16'h0004, ok);
        pull.ndac <= 1'b1;
    endtask
endmodule

`default_nettype wire

// >>> verif/gtl_device_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin $display("Error %s expected %0h seen %0h", nm, e, g); bad_count++; end end

module gtl_device_tb
    import gtl_pkg::*;
;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    gtl_bus_t   bus_lvl, bus_o, bus_oe, pull;
    logic [4:0] pri_addr = 5'h16;
    logic       tx_valid = 1'b0, tx_last = 1'b0, rx_ready = 1'b1, srq_req = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_ready, rx_valid, rx_end, cmd_valid, talk_act, listen_act, remote;
    logic [7:0] rx_data, cmd_data;
    logic [7:0] cmd_last = 8'h00;
    logic [8:0] rx_q[$];
    int         bad_count = 0;
    int         samples_checked = 0;

    always #12.5 clk = ~clk;
    // open-drain lines with pull-ups
    assign bus_lvl = gtl_bus_t'(~(bus_oe | pull));

    gtl_device u_gtl_device (
        .clk(clk), .sys_rst(sys_rst), .bus_i(bus_lvl), .bus_o(bus_o), .bus_oe(bus_oe),
        .pri_addr(pri_addr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_end(rx_end), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .srq_req(srq_req),
        .talk_act(talk_act), .listen_act(listen_act), .remote(remote)
    );
    gtl_ctl_model u_gtl_ctl_model (.clk(clk), .lvl(bus_lvl), .pull(pull));

    always @(negedge clk) begin
        if (rx_valid === 1'b1) rx_q.push_back({rx_end, rx_data});
        if (cmd_valid === 1'b1) cmd_last <= cmd_data;
    end

    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic okc(input bit ok);
        `CHK("handshake", 1'b1, ok)
        if (!ok) wrap_up();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic t_remote();
        `CHK("local", 1'b0, remote)
        u_gtl_ctl_model.drive(16'h0020, 16'h0020);
        srq_req <= 1'b1;
        tick(6);
        `CHK("remote", 1'b1, remote)
        `CHK("srq line", 1'b0, bus_lvl.srq)
        `CHK("pins", 16'h0000, bus_o)
        srq_req <= 1'b0;
        tick(6);
        `CHK("srq off", 1'b1, bus_lvl.srq)
    endtask

    // first data byte is held off by a busy user
    task automatic t_listen();
        bit ok;
        u_gtl_ctl_model.send(1'b1, 8'h36, 1'b0, ok);
        okc(ok);
        tick(4);
        `CHK("listen_act", 1'b1, listen_act)
        `CHK("cmd_data", 8'h36, cmd_last)
        rx_ready <= 1'b0;
        fork
            u_gtl_ctl_model.send(1'b0, 8'hA5, 1'b0, ok);
            begin
                tick(20);
                `CHK("nrfd held", 1'b0, bus_lvl.nrfd)
                `CHK("no byte", 0, rx_q.size())
                rx_ready <= 1'b1;
            end
        join
        okc(ok);
        u_gtl_ctl_model.send(1'b0, 8'h3C, 1'b1, ok);
        okc(ok);
        tick(4);
        `CHK("rx 0", 9'h0A5, rx_q[0])
        `CHK("rx 1", 9'h13C, rx_q[1])
        rx_q.delete();
        u_gtl_ctl_model.send(1'b1, 8'h76, 1'b0, ok);
        okc(ok);
        tick(4);
        `CHK("listen kept", 1'b1, listen_act)
        `CHK("talk kept", 1'b0, talk_act)
        u_gtl_ctl_model.send(1'b1, 8'h3F, 1'b0, ok);
        okc(ok);
        tick(4);
        `CHK("unlisten", 1'b0, listen_act)
        u_gtl_ctl_model.send(1'b1, 8'h36, 1'b0, ok);
        okc(ok);
        tick(4);
        `CHK("relisten", 1'b1, listen_act)
    endtask

    task automatic t_talk();
        logic [7:0] b;
        bit e, ok;
        int i, j, n;
        u_gtl_ctl_model.send(1'b1, 8'h56, 1'b0, ok);
        okc(ok);
        tick(4);
        `CHK("talk first", 1'b1, talk_act)
        // the controller names another talker; this one must step down
        u_gtl_ctl_model.send(1'b1, 8'h41, 1'b0, ok);
        okc(ok);
        tick(4);
        `CHK("other talker", 1'b0, talk_act)
        u_gtl_ctl_model.send(1'b1, 8'h56, 1'b0, ok);
        okc(ok);
        u_gtl_ctl_model.drive(16'h0080, 16'h0000);
        tick(4);
        `CHK("talk_act", 1'b1, talk_act)
        fork
            for (i = 0; i < 3; i++) begin
                tx_valid <= 1'b1;
                tx_data <= 8'hC0 + 8'(i);
                tx_last <= (i == 2);
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (tx_ready !== 1'b1 && n < 600);
                okc(n < 600);
                @(posedge clk);
                // drop the request at once so the last byte is not loaded again
                if (i == 2) tx_valid <= 1'b0;
            end
            for (j = 0; j < 3; j++) begin
                u_gtl_ctl_model.recv(b, e, ok);
                okc(ok);
                `CHK("tx byte", 8'hC0 + 8'(j), b)
                `CHK("eoi", (j == 2), e)
            end
        join
        tx_valid <= 1'b0;
    endtask

    task automatic t_ifc();
        `CHK("listen before", 1'b1, listen_act)
        u_gtl_ctl_model.drive(16'h0040, 16'h0040);
        tick(6);
        u_gtl_ctl_model.drive(16'h0040, 16'h0000);
        tick(4);
        `CHK("talk idle", 1'b0, talk_act)
        `CHK("listen idle", 1'b0, listen_act)
    endtask

    initial begin
        tick(6);
        sys_rst <= 1'b0;
        tick(2);
        t_remote();
        t_listen();
        t_talk();
        t_ifc();
        wrap_up();
    end
endmodule

`default_nettype wire
